// File: design/gpp_pkg.sv
package gpp_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_DIR0 = 8'hB8;
   localparam logic [7:0] IDX_DIR1 = 8'hC1;
   localparam logic [7:0] IDX_DIR2 = 8'hC2;
   localparam logic [7:0] IDX_DIR5 = 8'hC5;
   localparam logic [7:0] IDX_DAT0 = 8'hD0;
   localparam logic [7:0] IDX_DAT1 = 8'hD1;
   localparam logic [7:0] IDX_DAT2 = 8'hD2;
   localparam logic [7:0] IDX_DAT5 = 8'hD5;
   localparam logic [7:0] IDX_PU0 = 8'hE0;
   localparam logic [7:0] IDX_PU1 = 8'hE1;
   localparam logic [7:0] IDX_PU2 = 8'hE2;
   localparam logic [7:0] IDX_PU5 = 8'hE5;
   localparam logic [7:0] IDX_OD = 8'hE9;
   localparam logic [7:0] IDX_EDGE = 8'hBF;
   localparam logic [7:0] IDX_DIR_BITOP = 8'hF0;

   localparam int NPORT = 4;
   localparam int NPIN = 12;

   // implemented bits per port, slots 0..3 hold ports 0, 1, 2, 5
   localparam logic [3:0][7:0] DIR_MASK = {8'h10, 8'h3F, 8'h0D, 8'h01};
   localparam logic [3:0][7:0] DAT_WR_MASK = {8'h10, 8'h3F, 8'h0D, 8'h01};
   localparam logic [3:0][7:0] DAT_RD_MASK = {8'h10, 8'h3F, 8'h0F, 8'h01};
   localparam logic [3:0][7:0] PU_MASK = {8'h10, 8'h3F, 8'h0D, 8'h01};
   localparam logic [7:0] OD_MASK = 8'h01;
   localparam logic [7:0] EDGE_MASK = 8'h18;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] EDGE_RST = 8'h10;
   localparam int EDGE_LSB = 3;
   localparam int P11_BIT = 1;

   // flat pin positions
   localparam int PIN_P00 = 0;
   localparam int PIN_P10 = 1;
   localparam int PIN_P11 = 2;
   localparam int PIN_P12 = 3;
   localparam int PIN_P13 = 4;
   localparam int PIN_P54 = 11;

   // bit-op register fields
   localparam int BITOP_VAL = 7;
   localparam int BITOP_PORT_LSB = 4;

   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;

   typedef enum logic [2:0] {
      HCLK_IHRC, HCLK_RC, HCLK_32K, HCLK_4M, HCLK_12M, HCLK_INTERNAL_RC_WITH_RTC
   } gpp_hclk_e;

   typedef enum logic [2:0] {
      RK_NONE, RK_DIR, RK_DATA, RK_PU, RK_OD, RK_EDGE, RK_BITOP
   } gpp_reg_kind_e;

   typedef struct packed {
      logic dir;
      logic dat;
      logic pu;
      logic od;
   } gpp_pin_cfg_s;

   typedef struct packed {
      logic take;
      logic drive;
      logic level;
   } gpp_sf_s;

endpackage : gpp_pkg

// File: design/gpp_pin_cell.sv
`timescale 1ns/100ps
module gpp_pin_cell
   import gpp_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire gpp_pin_cfg_s cfg_i, // register settings for this pin
   input wire gpp_sf_s sf_i, // special-function takeover
   output logic pad_o, // level driven to pad
   output logic pad_oe_n_o, // low while driving
   output logic pullup_o // internal pull-up on
);
   logic drv_nxt;
   logic lvl_nxt;
   logic pu_nxt;

   always_comb begin
      if (sf_i.take) begin // [RULE_21]
         drv_nxt = sf_i.drive;
         lvl_nxt = sf_i.level;
         pu_nxt = 1'b0;
      end else if (cfg_i.od) begin
         // only ever sink; a high level is left to the board pull-up
         drv_nxt = ~cfg_i.dat; // [RULE_10]
         lvl_nxt = 1'b0;
         pu_nxt = 1'b0;
      end else begin
         drv_nxt = cfg_i.dir; // [RULE_02] [RULE_12]
         lvl_nxt = cfg_i.dat; // [RULE_13]
         pu_nxt = cfg_i.pu & ~cfg_i.dir; // [RULE_05] [RULE_06]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pad_o <= 1'b0;
         pad_oe_n_o <= 1'b1;
         pullup_o <= 1'b0;
      end else begin
         pad_o <= lvl_nxt;
         pad_oe_n_o <= ~drv_nxt;
         pullup_o <= pu_nxt;
      end
   end

endmodule : gpp_pin_cell

// File: design/gpp_edge_det.sv
`timescale 1ns/100ps
module gpp_edge_det
   import gpp_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic level_i, // sampled pin level
   input wire logic enable_i, // pin handed to interrupt
   input wire logic [1:0] sel_i, // edge selection
   output logic pulse_o // one-cycle edge event
);
   logic prev_r;
   logic pulse_nxt;

   always_comb begin
      unique case (sel_i) // [RULE_19]
         EDGE_RISE: pulse_nxt = level_i & ~prev_r;
         EDGE_FALL: pulse_nxt = ~level_i & prev_r;
         EDGE_BOTH: pulse_nxt = level_i ^ prev_r;
         default: pulse_nxt = 1'b0; // reserved code never fires
      endcase
      pulse_nxt = pulse_nxt & enable_i; // [RULE_18]
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_r <= 1'b0;
         pulse_o <= 1'b0;
      end else begin
         prev_r <= level_i;
         pulse_o <= pulse_nxt;
      end
   end

endmodule : gpp_edge_det

// File: design/gpp_ports.sv
// Notes on behaviour
// (RULE_01) twelve I/O pins on ports 0,1,2,5
// (RULE_02) direction bit 0 input, 1 output; reset input
// (RULE_03) single direction bits set or cleared alone
// (RULE_04) port1 bit1 input only, no direction bit
// (RULE_05) pull-up bit 1 enables pull-up; reset off
// (RULE_06) pull-up acts only in input mode
// (RULE_07) port1 bit1 has no pull-up bit
// (RULE_08) open-drain register bit0 enables port1 bit0
// (RULE_09) software sets output before open-drain
// (RULE_10) open-drain sinks low, releases high
// (RULE_11) software writes open-drain register whole byte
// (RULE_12) open-drain off restores direction-bit mode
// (RULE_13) data read gives pins, write loads latch
// (RULE_14) port1 bit1 read-only, reads 1 with reset option
// (RULE_15) port1 bit1 is reset input when option set
// (RULE_16) port1 bit2 crystal output for crystal options
// (RULE_17) port1 bit3 oscillator input for RC/crystal options
// (RULE_18) interrupt, PWM and buzzer pin takeovers
// (RULE_19) edge select 01 rise,10 fall,11 both
// (RULE_20) unimplemented bits ignore writes, read zero
// (RULE_21) special function overrides direction and data
`timescale 1ns/100ps
module gpp_ports
   import gpp_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input wire logic clk_i, // 40 MHz system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB write
   input wire logic [ADDR_W-1:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   input wire logic [3:0] pstrb_i, // APB byte strobes
   output logic pready_o, // APB ready
   output logic [31:0] prdata_o, // APB read data
   output logic pslverr_o, // APB error on unmapped address
   input wire logic [NPIN-1:0] pad_i, // pad levels
   output logic [NPIN-1:0] pad_o, // pad output levels
   output logic [NPIN-1:0] pad_oe_n_o, // pad drive enable, low drives
   output logic [NPIN-1:0] pullup_o, // pad pull-up enables
   input wire logic ext_irq_enable_i, // interrupt enable for port0 bit0
   input wire logic timer_counter_enable_i, // timer enable
   input wire logic pwm_output_select_i, // PWM onto port5 bit4
   input wire logic tone_output_select_i, // buzzer onto port5 bit4
   input wire logic pwm_output_i, // PWM waveform
   input wire logic buzzer_output_i, // buzzer waveform
   input wire logic reset_pin_opt_i, // option: port1 bit1 is reset
   input wire gpp_hclk_e high_clk_opt_i, // high clock option
   output logic ext_irq_edge_o, // interrupt edge event pulse
   output logic ext_reset_req_o, // reset pin asserted
   output logic osc_out_sel_o, // port1 bit2 is crystal output
   output logic osc_in_sel_o // port1 bit3 is oscillator input
);

   logic [3:0][7:0] dir_r;
   logic [3:0][7:0] dir_nxt;
   logic [3:0][7:0] dat_r;
   logic [3:0][7:0] dat_nxt;
   logic [3:0][7:0] pu_r;
   logic [3:0][7:0] pu_nxt;
   logic [7:0] od_r;
   logic [7:0] od_nxt;
   logic [7:0] edge_r;
   logic [7:0] edge_nxt;

   logic pready_nxt;
   logic [31:0] prdata_nxt;
   logic pslverr_nxt;
   logic acc_first;
   logic acc_wr;
   logic [1:0] bit_slot;
   logic [2:0] bit_pos;

   logic ext_reset_nxt;
   logic osc_out_nxt;
   logic osc_in_nxt;

   gpp_reg_kind_e kind;
   logic [1:0] slot;
   logic [7:0] idx;
   logic [3:0][7:0] pin_lvl;
   logic [NPIN-1:0] dir_flat;
   logic [NPIN-1:0] dat_flat;
   logic [NPIN-1:0] pu_flat;
   gpp_pin_cfg_s [NPIN-1:0] cfg;
   gpp_sf_s [NPIN-1:0] sf;

   // register slots holding port bits, flattened into pin order
   function automatic logic [NPIN-1:0] flatten(input logic [3:0][7:0] v);
      flatten = {v[3][4], v[2][5:0], v[1][3:0], v[0][0]}; // [RULE_01]
   endfunction : flatten

   assign idx = paddr_i[ADDR_W-1:2];

   always_comb begin
      kind = RK_NONE;
      slot = 2'd0;
      if (paddr_i[1:0] == 2'b00) begin
         unique case (idx)
            IDX_DIR0: begin
               kind = RK_DIR;
               slot = 2'd0;
            end
            IDX_DIR1: begin
               kind = RK_DIR;
               slot = 2'd1;
            end
            IDX_DIR2: begin
               kind = RK_DIR;
               slot = 2'd2;
            end
            IDX_DIR5: begin
               kind = RK_DIR;
               slot = 2'd3;
            end
            IDX_DAT0: begin
               kind = RK_DATA;
               slot = 2'd0;
            end
            IDX_DAT1: begin
               kind = RK_DATA;
               slot = 2'd1;
            end
            IDX_DAT2: begin
               kind = RK_DATA;
               slot = 2'd2;
            end
            IDX_DAT5: begin
               kind = RK_DATA;
               slot = 2'd3;
            end
            IDX_PU0: begin
               kind = RK_PU;
               slot = 2'd0;
            end
            IDX_PU1: begin
               kind = RK_PU;
               slot = 2'd1;
            end
            IDX_PU2: begin
               kind = RK_PU;
               slot = 2'd2;
            end
            IDX_PU5: begin
               kind = RK_PU;
               slot = 2'd3;
            end
            IDX_OD: kind = RK_OD;
            IDX_EDGE: kind = RK_EDGE;
            IDX_DIR_BITOP: kind = RK_BITOP;
            default: kind = RK_NONE;
         endcase
      end
   end

   // pad levels regrouped as data register images
   always_comb begin
      pin_lvl = '0;
      pin_lvl[0][0] = pad_i[PIN_P00];
      pin_lvl[1][3:0] = pad_i[PIN_P13:PIN_P10];
      pin_lvl[2][5:0] = pad_i[10:5];
      pin_lvl[3][4] = pad_i[PIN_P54];
      if (reset_pin_opt_i) begin
         pin_lvl[1][P11_BIT] = 1'b1; // [RULE_14]
      end
   end

   // register bus: one wait state, so read data leaves a flip-flop
   assign acc_first = psel_i && penable_i && !pready_o;
   // writes land only on the completing edge, when pready is seen high
   assign acc_wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
   assign bit_slot = pwdata_i[BITOP_PORT_LSB+1:BITOP_PORT_LSB];
   assign bit_pos = pwdata_i[2:0];

   always_comb begin
      pready_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      if (acc_first) begin
         pready_nxt = 1'b1;
         pslverr_nxt = (kind == RK_NONE);
         unique case (kind)
            RK_DIR: prdata_nxt = {24'h00_0000, dir_r[slot]};
            RK_DATA: prdata_nxt = {24'h00_0000, pin_lvl[slot] & DAT_RD_MASK[slot]}; // [RULE_13] [RULE_20]
            RK_EDGE: prdata_nxt = {24'h00_0000, edge_r};
            // pull-up, open-drain and bit-op registers are write-only
            RK_PU, RK_OD, RK_BITOP, RK_NONE: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= pready_nxt;
         prdata_o <= prdata_nxt;
         pslverr_o <= pslverr_nxt;
      end
   end

   always_comb begin
      dir_nxt = dir_r;
      dat_nxt = dat_r;
      pu_nxt = pu_r;
      od_nxt = od_r;
      edge_nxt = edge_r;
      if (acc_wr) begin
         unique case (kind)
            RK_DIR: dir_nxt[slot] = pwdata_i[7:0] & DIR_MASK[slot]; // [RULE_02] [RULE_04] [RULE_20]
            RK_DATA: dat_nxt[slot] = pwdata_i[7:0] & DAT_WR_MASK[slot]; // [RULE_13] [RULE_14]
            RK_PU: pu_nxt[slot] = pwdata_i[7:0] & PU_MASK[slot]; // [RULE_05] [RULE_07]
            RK_OD: od_nxt = pwdata_i[7:0] & OD_MASK; // [RULE_08]
            RK_EDGE: edge_nxt = pwdata_i[7:0] & EDGE_MASK; // [RULE_19]
            RK_BITOP: begin
               // touches one bit only; neighbours of the register stay put
               if (DIR_MASK[bit_slot][bit_pos]) begin
                  dir_nxt[bit_slot][bit_pos] = pwdata_i[BITOP_VAL]; // [RULE_03]
               end
            end
            RK_NONE: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dir_r <= {NPORT{REG_RST}};
         dat_r <= {NPORT{REG_RST}};
         pu_r <= {NPORT{REG_RST}};
         od_r <= REG_RST;
         edge_r <= EDGE_RST;
      end else begin
         dir_r <= dir_nxt;
         dat_r <= dat_nxt;
         pu_r <= pu_nxt;
         od_r <= od_nxt;
         edge_r <= edge_nxt;
      end
   end

   // special-function selection
   always_comb begin
      osc_out_nxt = 1'b0;
      osc_in_nxt = 1'b0;
      unique case (high_clk_opt_i)
         HCLK_IHRC: begin
            osc_out_nxt = 1'b0;
            osc_in_nxt = 1'b0;
         end
         // external RC needs only the input side
         HCLK_RC: begin
            osc_out_nxt = 1'b0;
            osc_in_nxt = 1'b1; // [RULE_17]
         end
         HCLK_32K, HCLK_4M, HCLK_12M, HCLK_INTERNAL_RC_WITH_RTC: begin
            osc_out_nxt = 1'b1; // [RULE_16]
            osc_in_nxt = 1'b1; // [RULE_17]
         end
         // spare option codes keep both pins as port pins
         default: begin
            osc_out_nxt = 1'b0;
            osc_in_nxt = 1'b0;
         end
      endcase
      ext_reset_nxt = reset_pin_opt_i & ~pad_i[PIN_P11]; // [RULE_15]
   end

   assign dir_flat = flatten(dir_r);
   assign dat_flat = flatten(dat_r);
   assign pu_flat = flatten(pu_r);

   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         cfg[i].dir = dir_flat[i];
         cfg[i].dat = dat_flat[i];
         cfg[i].pu = pu_flat[i];
         cfg[i].od = 1'b0;
      end
      cfg[PIN_P10].od = od_r[0]; // [RULE_08] [RULE_12]
   end

   always_comb begin
      sf = '0;
      // input-only pin: never driven, no pull-up
      sf[PIN_P11].take = 1'b1; // [RULE_04] [RULE_07]
      sf[PIN_P00].take = ext_irq_enable_i; // [RULE_18] [RULE_21]
      // oscillator pins released to the analog circuit
      sf[PIN_P12].take = osc_out_nxt; // [RULE_16]
      sf[PIN_P13].take = osc_in_nxt; // [RULE_17]
      if (timer_counter_enable_i && pwm_output_select_i) begin
         sf[PIN_P54].take = 1'b1; // [RULE_18]
         sf[PIN_P54].drive = 1'b1;
         sf[PIN_P54].level = pwm_output_i;
      end else if (timer_counter_enable_i && tone_output_select_i) begin
         // pwm wins when both selects are up, so the tone needs it low
         sf[PIN_P54].take = 1'b1; // [RULE_18]
         sf[PIN_P54].drive = 1'b1;
         sf[PIN_P54].level = buzzer_output_i;
      end
   end

   for (genvar g = 0; g < NPIN; g++) begin : g_pin
      gpp_pin_cell u_cell (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .cfg_i(cfg[g]),
         .sf_i(sf[g]),
         .pad_o(pad_o[g]),
         .pad_oe_n_o(pad_oe_n_o[g]),
         .pullup_o(pullup_o[g])
      );
   end

   gpp_edge_det u_edge (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .level_i(pad_i[PIN_P00]),
      .enable_i(ext_irq_enable_i),
      .sel_i(edge_r[EDGE_LSB+1:EDGE_LSB]),
      .pulse_o(ext_irq_edge_o)
   );

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_reset_req_o <= 1'b0;
         osc_out_sel_o <= 1'b0;
         osc_in_sel_o <= 1'b0;
      end else begin
         ext_reset_req_o <= ext_reset_nxt;
         osc_out_sel_o <= osc_out_nxt;
         osc_in_sel_o <= osc_in_nxt;
      end
   end

endmodule : gpp_ports

// File: verification/gpp_board.sv
`timescale 1ns/100ps
module gpp_board
   import gpp_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic [NPIN-1:0] drv_i, // device drive level
   input wire logic [NPIN-1:0] oe_n_i, // low while device drives
   input wire logic [NPIN-1:0] pu_i, // device pull-up on
   input wire logic [NPIN-1:0] ext_en_i, // board drives pin
   input wire logic [NPIN-1:0] ext_val_i, // board level
   output logic [NPIN-1:0] pin_o // resolved pin level
);
   logic [NPIN-1:0] flt_r = '0;
   // undriven pins wander so a stale level never passes
   always @(posedge clk_i) flt_r <= ~flt_r;
   always_comb begin
      pin_o = flt_r | pu_i;
      pin_o[PIN_P10] = 1'b1; // external resistor on open-drain pin
      pin_o = (pin_o & ~ext_en_i) | (ext_val_i & ext_en_i);
      pin_o = (pin_o & oe_n_i) | (drv_i & ~oe_n_i);
   end
endmodule : gpp_board

// File: verification/gpp_ports_monitor.sv
`timescale 1ns/100ps
module gpp_ports_monitor
   import gpp_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic psel_i, // select
   input wire logic penable_i, // enable
   input wire logic [ADDR_W-1:0] paddr_i, // address
   input wire logic pready_o, // ready
   input wire logic [31:0] prdata_o, // read data
   input wire logic pslverr_o, // error
   input wire logic [NPIN-1:0] pad_i, // pin levels
   input wire logic [NPIN-1:0] pad_oe_n_o, // drive enables
   input wire logic [NPIN-1:0] pullup_o, // pull-ups
   input wire logic ext_irq_enable_i, // irq enable
   input wire logic reset_pin_opt_i, // reset option
   input wire gpp_hclk_e high_clk_opt_i, // clock option
   input wire logic ext_irq_edge_o, // edge pulse
   input wire logic ext_reset_req_o, // reset request
   input wire logic osc_out_sel_o, // crystal out
   input wire logic osc_in_sel_o // osc in
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held");
   a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("ready late");
   a_idle_data: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data idle");
   a_misalign_err: assert property (pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o)
      else $error("no error");
   a_input_only: assert property (pad_oe_n_o[PIN_P11] && !pullup_o[PIN_P11])
      else $error("input pin driven");
   a_pullup_input: assert property ((pullup_o & ~pad_oe_n_o) == '0)
      else $error("pull-up on output");
   a_reset_pin: assert property (reset_pin_opt_i && !pad_i[PIN_P11] |=> ext_reset_req_o)
      else $error("reset missed");
   a_irq_input: assert property (ext_irq_enable_i |=> pad_oe_n_o[PIN_P00])
      else $error("irq pin driven");
   a_irq_gate: assert property (!ext_irq_enable_i [*2] |-> !ext_irq_edge_o)
      else $error("edge while off");
   a_osc_out: assert property (high_clk_opt_i inside {HCLK_32K, HCLK_4M, HCLK_12M,
      HCLK_INTERNAL_RC_WITH_RTC} |=> osc_out_sel_o)
      else $error("crystal out missed");
   a_osc_in: assert property (high_clk_opt_i != HCLK_IHRC |=> osc_in_sel_o)
      else $error("osc in missed");
endmodule : gpp_ports_monitor

bind gpp_ports gpp_ports_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_i, .rst_n_i, .psel_i, .penable_i,
   .paddr_i, .pready_o, .prdata_o, .pslverr_o, .pad_i, .pad_oe_n_o, .pullup_o, .ext_irq_enable_i,
   .reset_pin_opt_i, .high_clk_opt_i, .ext_irq_edge_o, .ext_reset_req_o, .osc_out_sel_o, .osc_in_sel_o);

// File: verification/gpp_ports_tb.sv
`timescale 1ns/100ps
module gpp_ports_tb;
   import gpp_pkg::*;
   logic clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [9:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, r;
   logic [3:0] pstrb_i = 4'h1;
   logic pready_o, pslverr_o, ext_irq_edge_o, ext_reset_req_o, osc_out_sel_o, osc_in_sel_o, e;
   logic [NPIN-1:0] pad_i, pad_o, pad_oe_n_o, pullup_o, een = 12'h004, evl = '0;
   logic ext_irq_enable_i = 0, timer_counter_enable_i = 0, pwm_output_select_i = 0;
   logic tone_output_select_i = 0, pwm_output_i = 0, buzzer_output_i = 0, reset_pin_opt_i = 0;
   gpp_hclk_e high_clk_opt_i = HCLK_IHRC;
   int error_cnt = 0, cmp_count = 0, np = 0, ex = 0;
   logic [7:0] di[4] = '{IDX_DIR0, IDX_DIR1, IDX_DIR2, IDX_DIR5};
   logic [7:0] dt[4] = '{IDX_DAT0, IDX_DAT1, IDX_DAT2, IDX_DAT5};
   logic [7:0] pu[4] = '{IDX_PU0, IDX_PU1, IDX_PU2, IDX_PU5};
   logic [7:0] dx[4] = '{8'h01, 8'h0D, 8'h3F, 8'h10};
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (ext_irq_edge_o === 1'b1) np <= np + 1;
   gpp_ports dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
      .pready_o, .prdata_o, .pslverr_o, .pad_i, .pad_o, .pad_oe_n_o, .pullup_o, .ext_irq_enable_i,
      .timer_counter_enable_i, .pwm_output_select_i, .tone_output_select_i, .pwm_output_i,
      .buzzer_output_i, .reset_pin_opt_i, .high_clk_opt_i, .ext_irq_edge_o, .ext_reset_req_o,
      .osc_out_sel_o, .osc_in_sel_o);
   gpp_board brd (.clk_i, .drv_i(pad_o), .oe_n_i(pad_oe_n_o), .pu_i(pullup_o), .ext_en_i(een),
      .ext_val_i(evl), .pin_o(pad_i));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask : apb
   function automatic logic [9:0] ad(input logic [7:0] i);
      return {i, 2'b00};
   endfunction : ad
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1, ad(i), d);
   endtask : wr
   task automatic rd(input logic [7:0] i, input logic [7:0] x);
      apb(0, ad(i), 0);
      chk($sformatf("reg %h", i), x, r);
   endtask : rd
   // pins follow a register one edge after the write lands
   task automatic st;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : st
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      #50us;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1;
      #1;
      chk("oe_n", 12'hFFF, pad_oe_n_o);
      for (int p = 0; p < 4; p++) begin
         rd(di[p], 8'h00);
         wr(pu[p], 8'h00);
         wr(di[p], 8'hFF);
         rd(di[p], DIR_MASK[p]);
         wr(dt[p], 8'hFF);
      end
      rd(IDX_OD, 8'h00);
      st;
      chk("oe_n", 12'h004, pad_oe_n_o);
      chk("drive", 12'hFFB, pad_o & ~pad_oe_n_o);
      for (int p = 0; p < 4; p++) rd(dt[p], dx[p]);
      @(posedge clk_i) reset_pin_opt_i <= 1;
      st;
      chk("rst", 1, ext_reset_req_o);
      rd(IDX_DAT1, 8'h0F);
      @(posedge clk_i) reset_pin_opt_i <= 0;
      wr(IDX_DIR_BITOP, 8'h23);
      rd(IDX_DIR2, 8'h37);
      wr(IDX_DIR_BITOP, 8'hA3);
      rd(IDX_DIR2, 8'h3F);
      for (int p = 0; p < 4; p++) begin
         wr(di[p], 8'h00);
         wr(pu[p], 8'hFF);
      end
      st;
      chk("pullup", 12'hFFB, pullup_o);
      rd(IDX_PU1, 8'h00);
      wr(IDX_DIR2, 8'h3F);
      st;
      chk("pullup", 12'h81B, pullup_o);
      wr(IDX_DIR1, 8'h01); // output first
      wr(IDX_DAT1, 8'h00);
      wr(IDX_OD, 8'h01); // whole byte
      st;
      chk("od", 0, {pad_oe_n_o[PIN_P10], pad_o[PIN_P10]});
      wr(IDX_DAT1, 8'h01);
      st;
      chk("od", 1, pad_oe_n_o[PIN_P10]);
      rd(IDX_DAT1, 8'h0D);
      wr(IDX_OD, 8'h00);
      st;
      chk("od", 1, {pad_oe_n_o[PIN_P10], pad_o[PIN_P10]});
      wr(IDX_DIR0, 8'h01);
      @(posedge clk_i) evl[0] <= 1;
      een[0] <= 1;
      @(posedge clk_i) ext_irq_enable_i <= 1;
      st;
      chk("irq pin", 1, pad_oe_n_o[PIN_P00]);
      for (int c = 0; c < 4; c++) begin
         wr(IDX_EDGE, 8'(c << EDGE_LSB));
         @(posedge clk_i) evl[0] <= 0;
         repeat (4) @(posedge clk_i);
         ex += c[1];
         chk("fall", ex, np);
         @(posedge clk_i) evl[0] <= 1;
         repeat (4) @(posedge clk_i);
         ex += c[0];
         chk("rise", ex, np);
      end
      @(posedge clk_i) timer_counter_enable_i <= 1;
      tone_output_select_i <= 1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i) pwm_output_select_i <= k[1];
         pwm_output_i <= k[0];
         buzzer_output_i <= ~k[0];
         st;
         chk("p54", 1'(~(k[0] ^ k[1])), {pad_oe_n_o[PIN_P54], pad_o[PIN_P54]});
      end
      @(posedge clk_i) tone_output_select_i <= 0;
      pwm_output_select_i <= 0;
      st;
      chk("p54", 1, pad_oe_n_o[PIN_P54]);
      @(posedge clk_i) timer_counter_enable_i <= 0;
      st;
      chk("p54", 1, pad_oe_n_o[PIN_P54]);
      for (int h = 0; h < 6; h++) begin
         @(posedge clk_i) high_clk_opt_i <= gpp_hclk_e'(h);
         st;
         chk("osc", {h > 1, h > 0}, {osc_out_sel_o, osc_in_sel_o});
      end
      apb(0, 10'h000, 8'h00);
      chk("err", 1, e);
      apb(1, ad(IDX_DIR0) | 10'h001, 8'h00);
      chk("err", 1, e);
      rd(IDX_DIR0, 8'h01);
      @(posedge clk_i) pstrb_i <= 4'h0;
      wr(IDX_DIR0, 8'h00);
      pstrb_i <= 4'h1;
      rd(IDX_DIR0, 8'h01);
      report_and_stop();
   end
endmodule : gpp_ports_tb
